// ### common/jtc_map.svh
`ifndef JTC_MAP_SVH
`define JTC_MAP_SVH

// instruction register
`define JTC_IR_WIDTH        4
`define JTC_IR_CAPTURE      4'h1
`define JTC_IR_BYPASS       4'hf
`define JTC_IR_USER         4'h2

// user data register
`define JTC_UDR_WIDTH       8

// ones on tms that reach test-logic-reset from anywhere
`define JTC_RESET_TMS_ONES  5

// host tms preambles, lsb applied first
`define JTC_IR_PRE_TMS      4'h3
`define JTC_IR_PRE_LEN      5'h04
`define JTC_DR_PRE_TMS      4'h1
`define JTC_DR_PRE_LEN      5'h03
`define JTC_POST_LEN        5'h02
`define JTC_RESET_TMS       16'h001f
`define JTC_RESET_LEN       5'h06

// host-made test clock
`define JTC_CORE_PERIOD_NS  20
`define JTC_TCK_PERIOD_NS   160
`define JTC_TCK_HALF_CYCLES \
    (`JTC_TCK_PERIOD_NS / (2 * `JTC_CORE_PERIOD_NS))

`endif

// ### common/jtc_pkg.sv
package jtc_pkg;

    // gray-coded along the usual walk through the diagram
    typedef enum logic [3:0] {
        JTC_TLR    = 4'h0,
        JTC_RTI    = 4'h1,
        JTC_SEL_DR = 4'h3,
        JTC_CAP_DR = 4'h2,
        JTC_SH_DR  = 4'h6,
        JTC_EX1_DR = 4'h7,
        JTC_PAU_DR = 4'h5,
        JTC_EX2_DR = 4'h4,
        JTC_UPD_DR = 4'hc,
        JTC_SEL_IR = 4'hd,
        JTC_CAP_IR = 4'hf,
        JTC_SH_IR  = 4'he,
        JTC_EX1_IR = 4'ha,
        JTC_PAU_IR = 4'hb,
        JTC_EX2_IR = 4'h9,
        JTC_UPD_IR = 4'h8
    } jtc_tap_state_type;

    typedef enum logic [1:0] {
        JTC_OP_RESET = 2'h0,
        JTC_OP_IR    = 2'h1,
        JTC_OP_DR    = 2'h2
    } jtc_host_op_type;

    typedef enum logic [1:0] {
        JTC_H_IDLE = 2'h0,
        JTC_H_LOW  = 2'h1,
        JTC_H_HIGH = 2'h3
    } jtc_host_state_type;

endpackage

// ### common/jtc_link_if.sv
`timescale 1ns/100ps

interface jtc_link_if;
    logic       host_tck;
    logic       host_tms;
    logic       host_tdi;
    logic       host_oe;
    logic       host_rst_oe;
    logic       ext_rst_oe;
    logic       dev_tdo;
    logic       dev_tdo_oe;
    logic [3:0] dev_gpio_out;
    logic [3:0] dev_gpio_oe;
    logic       dev_pull_en;
    logic       tck;
    logic       tms;
    logic       tdi;
    logic       tdo;
    logic       rst_n;

    // undriven test inputs float to the pull level when the port is on
    function automatic logic pin(input logic a_oe, input logic a_v,
                                 input logic b_oe, input logic b_v,
                                 input logic pull);
        pin = a_oe ? a_v : (b_oe ? b_v : pull);
    endfunction

    assign tck = pin(host_oe, host_tck, dev_gpio_oe[0], dev_gpio_out[0],
                     dev_pull_en);
    assign tms = pin(host_oe, host_tms, dev_gpio_oe[1], dev_gpio_out[1],
                     dev_pull_en);
    assign tdi = pin(host_oe, host_tdi, dev_gpio_oe[2], dev_gpio_out[2],
                     dev_pull_en);
    assign tdo = pin(dev_tdo_oe, dev_tdo, dev_gpio_oe[3], dev_gpio_out[3],
                     1'b1);
    // open-collector reset line with a pull-up
    assign rst_n = !(host_rst_oe || ext_rst_oe);

    modport device (
        input  tck,
        input  tms,
        input  tdi,
        input  tdo,
        output dev_tdo,
        output dev_tdo_oe,
        output dev_gpio_out,
        output dev_gpio_oe,
        output dev_pull_en
    );

    modport host (
        input  tdo,
        input  rst_n,
        output host_tck,
        output host_tms,
        output host_tdi,
        output host_oe,
        output host_rst_oe
    );
endinterface

// ### core/jtc_tap_device.sv
`timescale 1ns/100ps
`include "jtc_map.svh"

// Notes on behaviour
// - only tms steers state changes
// - all port logic runs on tck
// - tdi shifts into selected register
// - tdo carries the selected register's bits
// - no test reset pin; power-on only
// - fuse off: gpio pins, controller held reset
// - fuse on: inputs pulled high, port enabled
// - debugger watches system reset line
// - debugger may pull open-collector reset low
// - controller has exactly sixteen states
// - tms sampled on rising tck decides
// - power-on starts in test-logic-reset
// - every register shifts lsb first
// - tms 1,1,0,0 from idle reaches shift-ir
// - four-bit instructions, one bit per edge
// - tms low for lower three bits
// - last bit enters as shift state exits
// - shift-ir sends fixed capture pattern out
// - instruction latched in update-ir; test-logic-reset loads bypass
// - five tms ones reach test-logic-reset
module jtc_tap_device (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_resetn,
    input  wire logic                      i_clk_en,
    input  wire logic                      i_test_port_enable_fuse,
    input  wire logic [3:0]                i_gpio_out,
    input  wire logic [3:0]                i_gpio_oe,
    output logic      [3:0]                o_gpio_in_q,
    output logic      [`JTC_IR_WIDTH-1:0]  o_instr_q,
    output logic      [`JTC_UDR_WIDTH-1:0] o_user_data_q,
    output logic                           o_update_q,
    jtc_link_if.device                     lnk
);
    import jtc_pkg::*;

    logic                      tck;
    logic                      fuse_t1_q;
    logic                      fuse_t2_q;
    logic                      ce_t1_q;
    logic                      ce_t2_q;
    jtc_tap_state_type         state_q;
    jtc_tap_state_type         state_d;
    logic [`JTC_IR_WIDTH-1:0]  ir_sh_q;
    logic [`JTC_IR_WIDTH-1:0]  ir_sh_d;
    logic [`JTC_IR_WIDTH-1:0]  ir_q;
    logic [`JTC_IR_WIDTH-1:0]  ir_d;
    logic [`JTC_UDR_WIDTH-1:0] dr_sh_q;
    logic [`JTC_UDR_WIDTH-1:0] dr_sh_d;
    logic [`JTC_UDR_WIDTH-1:0] dr_hold_q;
    logic [`JTC_UDR_WIDTH-1:0] dr_hold_d;
    logic                      byp_q;
    logic                      byp_d;
    logic                      tgl_q;
    logic                      tgl_d;
    logic                      user_sel;
    logic                      tdo_q;
    logic                      tdo_d;
    logic                      tdo_oe_q;
    logic                      tdo_oe_d;

    assign tck = lnk.tck;
    assign user_sel = (ir_q == `JTC_IR_USER);

    // the fuse is a static strap, the enable is core-side: both resync
    always_ff @(posedge tck or negedge i_resetn) begin
        if (!i_resetn) begin
            fuse_t1_q <= 1'b0;
            fuse_t2_q <= 1'b0;
            ce_t1_q   <= 1'b0;
            ce_t2_q   <= 1'b0;
        end else begin
            fuse_t1_q <= i_test_port_enable_fuse;
            fuse_t2_q <= fuse_t1_q;
            ce_t1_q   <= i_clk_en;
            ce_t2_q   <= ce_t1_q;
        end
    end

    always_comb begin
        state_d   = state_q;
        ir_sh_d   = ir_sh_q;
        ir_d      = ir_q;
        dr_sh_d   = dr_sh_q;
        dr_hold_d = dr_hold_q;
        byp_d     = byp_q;
        tgl_d     = tgl_q;
        if (!fuse_t2_q) begin
            state_d = JTC_TLR;
            ir_d    = `JTC_IR_BYPASS;
        end else if (ce_t2_q) begin
            // tms alone picks the next state
            case (state_q)
                JTC_TLR:    state_d = lnk.tms ? JTC_TLR : JTC_RTI;
                JTC_RTI:    state_d = lnk.tms ? JTC_SEL_DR : JTC_RTI;
                JTC_SEL_DR: state_d = lnk.tms ? JTC_SEL_IR : JTC_CAP_DR;
                JTC_CAP_DR: state_d = lnk.tms ? JTC_EX1_DR : JTC_SH_DR;
                JTC_SH_DR:  state_d = lnk.tms ? JTC_EX1_DR : JTC_SH_DR;
                JTC_EX1_DR: state_d = lnk.tms ? JTC_UPD_DR : JTC_PAU_DR;
                JTC_PAU_DR: state_d = lnk.tms ? JTC_EX2_DR : JTC_PAU_DR;
                JTC_EX2_DR: state_d = lnk.tms ? JTC_UPD_DR : JTC_SH_DR;
                JTC_UPD_DR: state_d = lnk.tms ? JTC_SEL_DR : JTC_RTI;
                // any state ends here after five ones
                JTC_SEL_IR: state_d = lnk.tms ? JTC_TLR : JTC_CAP_IR;
                JTC_CAP_IR: state_d = lnk.tms ? JTC_EX1_IR : JTC_SH_IR;
                JTC_SH_IR:  state_d = lnk.tms ? JTC_EX1_IR : JTC_SH_IR;
                JTC_EX1_IR: state_d = lnk.tms ? JTC_UPD_IR : JTC_PAU_IR;
                JTC_PAU_IR: state_d = lnk.tms ? JTC_EX2_IR : JTC_PAU_IR;
                JTC_EX2_IR: state_d = lnk.tms ? JTC_UPD_IR : JTC_SH_IR;
                JTC_UPD_IR: state_d = lnk.tms ? JTC_SEL_DR : JTC_RTI;
                default:    state_d = JTC_TLR;
            endcase
            // actions take effect on the edge that leaves the state
            case (state_q)
                JTC_TLR: begin
                    // a reset instruction must reach the core side too
                    ir_d  = `JTC_IR_BYPASS;
                    tgl_d = (ir_q != `JTC_IR_BYPASS) ? !tgl_q : tgl_q;
                end
                JTC_CAP_IR: begin
                    ir_sh_d = `JTC_IR_CAPTURE;
                end
                JTC_SH_IR: begin
                    // still shifts on the exit edge
                    ir_sh_d = {lnk.tdi, ir_sh_q[`JTC_IR_WIDTH-1:1]};
                end
                JTC_UPD_IR: begin
                    ir_d  = ir_sh_q;
                    tgl_d = !tgl_q;
                end
                JTC_CAP_DR: begin
                    if (user_sel) begin
                        dr_sh_d = dr_hold_q;
                    end else begin
                        byp_d = 1'b0;
                    end
                end
                JTC_SH_DR: begin
                    if (user_sel) begin
                        dr_sh_d = {lnk.tdi, dr_sh_q[`JTC_UDR_WIDTH-1:1]};
                    end else begin
                        byp_d = lnk.tdi;
                    end
                end
                JTC_UPD_DR: begin
                    if (user_sel) begin
                        dr_hold_d = dr_sh_q;
                        tgl_d     = !tgl_q;
                    end
                end
                default: begin
                    tgl_d = tgl_q;
                end
            endcase
        end
    end

    // power-on is the only asynchronous reset of the controller
    always_ff @(posedge tck or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q   <= JTC_TLR;
            ir_sh_q   <= `JTC_IR_CAPTURE;
            ir_q      <= `JTC_IR_BYPASS;
            dr_sh_q   <= '0;
            dr_hold_q <= '0;
            byp_q     <= 1'b0;
            tgl_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            ir_sh_q   <= ir_sh_d;
            ir_q      <= ir_d;
            dr_sh_q   <= dr_sh_d;
            dr_hold_q <= dr_hold_d;
            byp_q     <= byp_d;
            tgl_q     <= tgl_d;
        end
    end

    always_comb begin
        tdo_d    = tdo_q;
        tdo_oe_d = 1'b0;
        if (state_q == JTC_SH_IR) begin
            tdo_d    = ir_sh_q[0];
            tdo_oe_d = fuse_t2_q;
        end else if (state_q == JTC_SH_DR) begin
            tdo_d    = user_sel ? dr_sh_q[0] : byp_q;
            tdo_oe_d = fuse_t2_q;
        end
    end

    // falling edge gives the host a full half period of setup
    always_ff @(negedge tck or negedge i_resetn) begin
        if (!i_resetn) begin
            tdo_q    <= 1'b1;
            tdo_oe_q <= 1'b0;
        end else if (ce_t2_q) begin
            tdo_q    <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end

    assign lnk.dev_tdo    = tdo_q;
    assign lnk.dev_tdo_oe = tdo_oe_q;

    // core side: gpio mode, pull control, update hand-over
    logic       fuse_c1_q;
    logic       fuse_c2_q;
    logic [3:0] pin_s1_q;
    logic [3:0] gpio_out_q;
    logic [3:0] gpio_oe_q;
    logic [3:0] gpio_oe_d;
    logic       pull_q;
    logic       tgl_s1_q;
    logic       tgl_s2_q;
    logic       tgl_s3_q;
    logic       upd_d;

    always_comb begin
        // pins belong to the test port whenever the fuse is on
        gpio_oe_d = fuse_c2_q ? 4'h0 : i_gpio_oe;
        upd_d     = tgl_s2_q ^ tgl_s3_q;
    end

    // ir and hold register are stable long before the toggle lands
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fuse_c1_q     <= 1'b0;
            fuse_c2_q     <= 1'b0;
            pin_s1_q      <= 4'h0;
            o_gpio_in_q   <= 4'h0;
            gpio_out_q    <= 4'h0;
            gpio_oe_q     <= 4'h0;
            pull_q        <= 1'b0;
            tgl_s1_q      <= 1'b0;
            tgl_s2_q      <= 1'b0;
            tgl_s3_q      <= 1'b0;
            o_instr_q     <= `JTC_IR_BYPASS;
            o_user_data_q <= '0;
            o_update_q    <= 1'b0;
        end else if (i_clk_en) begin
            fuse_c1_q   <= i_test_port_enable_fuse;
            fuse_c2_q   <= fuse_c1_q;
            pin_s1_q    <= {lnk.tdo, lnk.tdi, lnk.tms, lnk.tck};
            o_gpio_in_q <= pin_s1_q;
            gpio_out_q  <= i_gpio_out;
            gpio_oe_q   <= gpio_oe_d;
            pull_q      <= fuse_c2_q;
            tgl_s1_q    <= tgl_q;
            tgl_s2_q    <= tgl_s1_q;
            tgl_s3_q    <= tgl_s2_q;
            o_update_q  <= upd_d;
            if (upd_d) begin
                o_instr_q     <= ir_q;
                o_user_data_q <= dr_hold_q;
            end
        end
    end

    assign lnk.dev_gpio_out = gpio_out_q;
    assign lnk.dev_gpio_oe  = gpio_oe_q;
    assign lnk.dev_pull_en  = pull_q;
endmodule

// ### core/jtc_tap_host.sv
`timescale 1ns/100ps
`include "jtc_map.svh"

module jtc_tap_host (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_resetn,
    input  wire logic                      i_clk_en,
    input  wire logic                      i_start,
    input  jtc_pkg::jtc_host_op_type       i_op,
    input  wire logic [3:0]                i_len,
    input  wire logic [`JTC_UDR_WIDTH-1:0] i_wdata,
    input  wire logic                      i_sys_reset_req,
    output logic                           o_busy_q,
    output logic                           o_done_q,
    output logic      [`JTC_UDR_WIDTH-1:0] o_rdata_q,
    output logic                           o_sys_in_reset_q,
    jtc_link_if.host                       lnk
);
    import jtc_pkg::*;

    localparam logic [3:0] HALF_LAST = 4'(`JTC_TCK_HALF_CYCLES - 1);

    jtc_host_state_type st_q;
    jtc_host_state_type st_d;
    logic [15:0] tms_vec_q;
    logic [15:0] tms_vec_d;
    logic [15:0] tdi_vec_q;
    logic [15:0] tdi_vec_d;
    logic [4:0]  idx_q;
    logic [4:0]  idx_d;
    logic [4:0]  cnt_all_q;
    logic [4:0]  cnt_all_d;
    logic [4:0]  pre_q;
    logic [4:0]  pre_d;
    logic [3:0]  len_q;
    logic [3:0]  len_d;
    logic [3:0]  tim_q;
    logic [3:0]  tim_d;
    logic [7:0]  rx_q;
    logic [7:0]  rx_d;
    logic        tck_d;
    logic        tms_d;
    logic        tdi_d;
    logic        done_d;
    logic [7:0]  rdata_d;
    logic        tck_q;
    logic        tms_q;
    logic        tdi_q;
    logic        oe_q;
    logic        rst_oe_q;
    logic        tdo_s1_q;
    logic        tdo_s2_q;
    logic        rst_s1_q;

    // one-hot bit at a tms/tdi vector position
    function automatic logic [15:0] bit_at(input logic [4:0] pos);
        bit_at = 16'h0001 << pos[3:0];
    endfunction

    always_comb begin
        st_d      = st_q;
        tms_vec_d = tms_vec_q;
        tdi_vec_d = tdi_vec_q;
        idx_d     = idx_q;
        cnt_all_d = cnt_all_q;
        pre_d     = pre_q;
        len_d     = len_q;
        tim_d     = tim_q;
        rx_d      = rx_q;
        tck_d     = tck_q;
        tms_d     = tms_q;
        tdi_d     = tdi_q;
        done_d    = 1'b0;
        rdata_d   = o_rdata_q;
        case (st_q)
            JTC_H_IDLE: begin
                tck_d = 1'b0;
                if (i_start) begin
                    len_d = (i_len == 4'h0) ? 4'h1 : i_len;
                    tdi_vec_d = '0;
                    if (i_op == JTC_OP_RESET) begin
                        pre_d     = `JTC_RESET_LEN;
                        len_d     = 4'h0;
                        tms_vec_d = `JTC_RESET_TMS;
                        cnt_all_d = `JTC_RESET_LEN;
                    end else begin
                        pre_d = (i_op == JTC_OP_IR) ? `JTC_IR_PRE_LEN
                                                    : `JTC_DR_PRE_LEN;
                        cnt_all_d = pre_d + 5'(len_d) + `JTC_POST_LEN;
                        // preamble, last shift bit high, then update
                        tms_vec_d = {12'h000, (i_op == JTC_OP_IR)
                                     ? `JTC_IR_PRE_TMS : `JTC_DR_PRE_TMS}
                                  | bit_at(pre_d + 5'(len_d) - 5'h01)
                                  | bit_at(pre_d + 5'(len_d));
                        tdi_vec_d = 16'({8'h00, i_wdata} << pre_d[3:0]);
                    end
                    idx_d = 5'h00;
                    tim_d = 4'h0;
                    rx_d  = 8'h00;
                    tms_d = tms_vec_d[0];
                    tdi_d = tdi_vec_d[0];
                    st_d  = JTC_H_LOW;
                end
            end
            JTC_H_LOW: begin
                tim_d = tim_q + 4'h1;
                if (tim_q == HALF_LAST) begin
                    // lsb arrives first, so fill from the top
                    if (idx_q >= pre_q && idx_q < pre_q + 5'(len_q)) begin
                        rx_d = {tdo_s2_q, rx_q[7:1]};
                    end
                    tck_d = 1'b1;
                    tim_d = 4'h0;
                    st_d  = JTC_H_HIGH;
                end
            end
            JTC_H_HIGH: begin
                tim_d = tim_q + 4'h1;
                if (tim_q == HALF_LAST) begin
                    tck_d = 1'b0;
                    tim_d = 4'h0;
                    idx_d = idx_q + 5'h01;
                    if (idx_d == cnt_all_q) begin
                        done_d  = 1'b1;
                        rdata_d = rx_q >> (4'h8 - len_q);
                        st_d    = JTC_H_IDLE;
                    end else begin
                        tms_d = tms_vec_q[idx_d[3:0]];
                        tdi_d = tdi_vec_q[idx_d[3:0]];
                        st_d  = JTC_H_LOW;
                    end
                end
            end
            default: begin
                st_d = JTC_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q             <= JTC_H_IDLE;
            tms_vec_q        <= '0;
            tdi_vec_q        <= '0;
            idx_q            <= '0;
            cnt_all_q        <= '0;
            pre_q            <= '0;
            len_q            <= '0;
            tim_q            <= '0;
            rx_q             <= '0;
            tck_q            <= 1'b0;
            tms_q            <= 1'b1;
            tdi_q            <= 1'b1;
            oe_q             <= 1'b0;
            o_busy_q         <= 1'b0;
            o_done_q         <= 1'b0;
            o_rdata_q        <= '0;
            rst_oe_q         <= 1'b0;
            tdo_s1_q         <= 1'b1;
            tdo_s2_q         <= 1'b1;
            rst_s1_q         <= 1'b0;
            o_sys_in_reset_q <= 1'b0;
        end else if (i_clk_en) begin
            st_q             <= st_d;
            tms_vec_q        <= tms_vec_d;
            tdi_vec_q        <= tdi_vec_d;
            idx_q            <= idx_d;
            cnt_all_q        <= cnt_all_d;
            pre_q            <= pre_d;
            len_q            <= len_d;
            tim_q            <= tim_d;
            rx_q             <= rx_d;
            tck_q            <= tck_d;
            tms_q            <= tms_d;
            tdi_q            <= tdi_d;
            oe_q             <= 1'b1;
            o_busy_q         <= (st_d != JTC_H_IDLE);
            o_done_q         <= done_d;
            o_rdata_q        <= rdata_d;
            rst_oe_q         <= i_sys_reset_req;
            tdo_s1_q         <= lnk.tdo;
            tdo_s2_q         <= tdo_s1_q;
            rst_s1_q         <= !lnk.rst_n;
            o_sys_in_reset_q <= rst_s1_q;
        end
    end

    assign lnk.host_tck    = tck_q;
    assign lnk.host_tms    = tms_q;
    assign lnk.host_tdi    = tdi_q;
    assign lnk.host_oe     = oe_q;
    assign lnk.host_rst_oe = rst_oe_q;
endmodule

// ### dv/jtc_tap_assertions.sv
`timescale 1ns/100ps
module jtc_tap_assertions (
    input wire logic       i_core_clk,
    input wire logic       i_resetn,
    input wire logic       host_tck,
    input wire logic       host_tms,
    input wire logic       host_tdi,
    input wire logic       tck,
    input wire logic       tms,
    input wire logic       dev_tdo,
    input wire logic       dev_tdo_oe,
    input wire logic [3:0] dev_gpio_oe,
    input wire logic       dev_pull_en
);
    a_port_off_quiet: assert property (@(posedge tck)
        disable iff (!i_resetn) !dev_pull_en |-> !dev_tdo_oe)
        else $error("tdo driven while port off");
    a_tdo_falling_only: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn) tck && $past(tck) |-> $stable(dev_tdo)
        && $stable(dev_tdo_oe)) else $error("tdo moved while tck high");
    a_shift_exit_off: assert property (@(posedge tck)
        disable iff (!i_resetn) tms |=> !dev_tdo_oe)
        else $error("tdo still driven after exit");
    a_shift_entry_path: assert property (@(posedge tck)
        disable iff (!i_resetn) $rose(dev_tdo_oe) |-> !$past(tms)
        && !$past(tms, 2)) else $error("shift entered without two zeros");
    a_ir_capture_out: assert property (@(posedge tck)
        disable iff (!i_resetn) !$past(tms, 5) && $past(tms, 4)
        && $past(tms, 3) && $rose(dev_tdo_oe)
        |-> dev_tdo ##1 !dev_tdo [*3]) else $error("wrong ir capture bits");
    a_tck_high_span: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn) $rose(host_tck)
        |-> host_tck [*4] ##1 !host_tck)
        else $error("tck high phase wrong");
    a_tms_setup_hold: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn) host_tck |-> $stable(host_tms)
        && $stable(host_tdi)) else $error("tms or tdi moved while tck high");
    a_gpio_off_fuse: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn) dev_pull_en |-> dev_gpio_oe == 4'h0)
        else $error("gpio driven while port on");
endmodule

// ### dv/jtag_tap_controller_test.sv
`timescale 1ns/100ps
module jtag_tap_controller_test;
    import jtc_pkg::*;
    logic            i_core_clk = 1'b0;
    logic            i_resetn   = 1'b1;
    logic            ce         = 1'b1;
    logic            fuse       = 1'b1;
    logic            i_start    = 1'b0;
    jtc_host_op_type i_op       = JTC_OP_RESET;
    logic [3:0]      i_len      = 4'h1;
    logic [7:0]      i_wdata    = 8'h00;
    logic            sys_req    = 1'b0;
    logic [3:0]      gpio_out   = 4'h0;
    logic [3:0]      gpio_oe    = 4'hf;
    logic [3:0]      gpio_in;
    logic [3:0]      instr;
    logic [7:0]      udata;
    logic [7:0]      rdata;
    logic [7:0]      got;
    logic            upd;
    logic            busy;
    logic            done;
    logic            sys_rst;
    int              failures   = 0;
    int              num_checks = 0;
    int              cycles     = 0;
    int              upd_n      = 0;
    int              base;
    jtc_link_if lnk ();
    jtc_tap_device jtc_tap_device_i (.i_core_clk(i_core_clk),
        .i_resetn(i_resetn), .i_clk_en(ce), .i_test_port_enable_fuse(fuse),
        .i_gpio_out(gpio_out), .i_gpio_oe(gpio_oe), .o_gpio_in_q(gpio_in),
        .o_instr_q(instr), .o_user_data_q(udata), .o_update_q(upd),
        .lnk(lnk));
    jtc_tap_host jtc_tap_host_i (.i_core_clk(i_core_clk),
        .i_resetn(i_resetn), .i_clk_en(ce), .i_start(i_start), .i_op(i_op),
        .i_len(i_len), .i_wdata(i_wdata), .i_sys_reset_req(sys_req),
        .o_busy_q(busy), .o_done_q(done), .o_rdata_q(rdata),
        .o_sys_in_reset_q(sys_rst), .lnk(lnk));
    jtc_tap_assertions jtc_tap_assertions_i (.i_core_clk(i_core_clk),
        .i_resetn(i_resetn), .host_tck(lnk.host_tck), .host_tms(lnk.host_tms),
        .host_tdi(lnk.host_tdi), .tck(lnk.tck), .tms(lnk.tms),
        .dev_tdo(lnk.dev_tdo), .dev_tdo_oe(lnk.dev_tdo_oe),
        .dev_gpio_oe(lnk.dev_gpio_oe), .dev_pull_en(lnk.dev_pull_en));

    initial forever #10 i_core_clk = ~i_core_clk;

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // a hung handshake ends up here instead of running forever
    always @(posedge i_core_clk) begin
        cycles++;
        if (upd === 1'b1)
            upd_n++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    task automatic restart(input logic f);
        i_resetn = 1'b0;
        fuse = f;
        tick(10);
        i_resetn = 1'b1;
        tick(4);
    endtask

    // settle time after done lets the update crossing land
    task automatic run(input jtc_host_op_type op, input logic [3:0] len,
                       input logic [7:0] wd);
        int n;
        tick(1);
        i_op = op;
        i_len = len;
        i_wdata = wd;
        i_start = 1'b1;
        tick(1);
        i_start = 1'b0;
        check(busy, 8'h01);
        for (n = 0; n < 400 && done !== 1'b1; n++)
            tick(1);
        check(done, 8'h01);
        got = rdata;
        tick(8);
    endtask

    initial begin
        lnk.ext_rst_oe = 1'b0;
        // a real falling edge on reset clears the tck-side flops too
        tick(1);
        restart(1'b1);
        check(instr, 8'h0f);
        run(JTC_OP_RESET, 4'h1, 8'h00);
        base = upd_n;
        run(JTC_OP_IR, 4'h4, 8'h02);
        check(got & 8'h0f, 8'h01);
        check(instr, 8'h02);
        run(JTC_OP_DR, 4'h8, 8'ha5);
        check(got, 8'h00);
        check(udata, 8'ha5);
        run(JTC_OP_DR, 4'h8, 8'h3c);
        check(got, 8'ha5);
        check(udata, 8'h3c);
        check(8'(upd_n - base), 8'h03);
        run(JTC_OP_IR, 4'h4, 8'h0f);
        check(instr, 8'h0f);
        run(JTC_OP_DR, 4'h3, 8'h05);
        check(got & 8'h07, 8'h02);
        check(udata, 8'h3c);
        run(JTC_OP_IR, 4'h4, 8'h02);
        run(JTC_OP_RESET, 4'h1, 8'h00);
        check(instr, 8'h0f);
        // a frozen host must not pass the request on
        ce = 1'b0;
        sys_req = 1'b1;
        tick(6);
        check(sys_rst, 8'h00);
        ce = 1'b1;
        tick(6);
        check(sys_rst, 8'h01);
        sys_req = 1'b0;
        tick(6);
        check(sys_rst, 8'h00);
        lnk.ext_rst_oe = 1'b1;
        tick(6);
        check(sys_rst, 8'h01);
        lnk.ext_rst_oe = 1'b0;
        restart(1'b0);
        tick(4);
        check(gpio_in, 8'h06);
        base = upd_n;
        run(JTC_OP_IR, 4'h4, 8'h02);
        check(got & 8'h0f, 8'h00);
        check(instr, 8'h0f);
        check(8'(upd_n - base), 8'h00);
        complete_run();
    end
endmodule
